//--- design/system_clock_control.sv
// system clock control register, source selection and failure monitor
//
// What this block does
// - every reset sets the speed-up bit
// - software sets or clears speed-up freely
// - speed-up acts only under option 011
// - divider field gives 1, 2, 4, 12
// - low-frequency source passes undivided under option 011
// - rc enable bit turns rc on or off
// - source bit picks low-frequency or rc
// - rc enable and source need option 011
// - rc enable cannot clear while rc selected
// - rc selected disables the failure monitor
// - failure flag is set/cleared by hardware
// - prescaler input from oscillator, rc, or watchdog rc on failure
`timescale 1ns/100ps
`default_nettype none
module system_clock_control (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cpu_instruction_clock_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cpu_instruction_clock_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [cpu_instruction_clock_pkg::DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,
  // oscillator pins
  input  wire logic                          selected_oscillator_clock,
  input  wire logic                          internal_rc_clock,
  input  wire logic                          watchdog_rc_clock,
  input  wire logic                          oscillator_failed,
  input  wire logic [2:0]                    oscillator_config_option,
  // oscillator controls
  output logic                               internal_rc_enable,
  output logic                               low_freq_osc_speedup,
  output logic                               clock_failure_flag,
  output logic                               clock_monitor_active,
  // clock ticks
  output logic                               prescaler_input_clock,
  output logic                               cpu_instruction_clock
);

  typedef struct packed {
    logic [cpu_instruction_clock_pkg::SYNC_W-1:0] sync_a;
    logic [cpu_instruction_clock_pkg::SYNC_W-1:0] sync_b;
    logic [cpu_instruction_clock_pkg::CLK_W-1:0]  clk_prev;
    logic                          speedup;
    logic [1:0]                    div_sel;
    logic                          fail_flag;
    logic                          rc_en;
    logic                          src_sel;
    logic [cpu_instruction_clock_pkg::REG_W-1:0]  rd_data;
    logic                          tick;
    logic                          rc_on_out;
    logic                          speedup_out;
    logic                          monitor_active;
    cpu_instruction_clock_pkg::source_t           source;
  } state_t;

  localparam state_t ST_RESET = '{
    speedup:   cpu_instruction_clock_pkg::SPEEDUP_RST,
    div_sel:   cpu_instruction_clock_pkg::DIV_RST,
    fail_flag: cpu_instruction_clock_pkg::FAIL_RST,
    rc_en:     cpu_instruction_clock_pkg::RC_EN_RST,
    src_sel:   cpu_instruction_clock_pkg::SRC_SEL_RST,
    source:    cpu_instruction_clock_pkg::SRC_LF,
    default:   '0
  };

  state_t                        st;
  state_t                        next_st;
  logic                          hit_ctrl;
  logic                          hit_stat;
  logic                          wr_ctrl;
  logic                          cfg_valid;
  logic                          rc_selected;
  logic                          monitor_on;
  logic                          osc_failed;
  logic                          bypass;
  logic [cpu_instruction_clock_pkg::CLK_W-1:0]  rising;
  logic [1:0]                    eff_div;
  logic [cpu_instruction_clock_pkg::REG_W-1:0]  ctrl_val;
  logic [cpu_instruction_clock_pkg::REG_W-1:0]  stat_val;

  // ==========================================================
  // apb decode
  assign hit_ctrl = paddr == cpu_instruction_clock_pkg::CLK_CTRL_ADDR;
  assign hit_stat = paddr == cpu_instruction_clock_pkg::CLK_STAT_ADDR;
  assign wr_ctrl  = psel && penable && pwrite && hit_ctrl && pstrb[0];
  assign pready   = clk_en;
  assign pslverr  = psel && penable && !(hit_ctrl || hit_stat);
  assign prdata   = {{(cpu_instruction_clock_pkg::DATA_W-cpu_instruction_clock_pkg::REG_W){1'b0}},
                     st.rd_data};

  // ==========================================================
  // clock selection terms
  assign cfg_valid   = st.sync_b[cpu_instruction_clock_pkg::PIN_CFG+2:cpu_instruction_clock_pkg::PIN_CFG]
                       == cpu_instruction_clock_pkg::CFG_LF_XTAL;
  assign rc_selected = cfg_valid && st.src_sel;
  assign monitor_on  = !rc_selected;
  assign osc_failed  = st.sync_b[cpu_instruction_clock_pkg::PIN_FAIL];
  assign rising      = st.sync_b[cpu_instruction_clock_pkg::CLK_W-1:0] & ~st.clk_prev;
  assign bypass      = cfg_valid && st.source == cpu_instruction_clock_pkg::SRC_LF;
  assign eff_div     = bypass ? cpu_instruction_clock_pkg::DIV_CODE_1 : st.div_sel;

  // ==========================================================
  // register images
  always_comb
  begin
    ctrl_val = '0;
    ctrl_val[cpu_instruction_clock_pkg::SPEEDUP_BIT] = st.speedup;
    ctrl_val[cpu_instruction_clock_pkg::DIV_HI_BIT:cpu_instruction_clock_pkg::DIV_LO_BIT] = st.div_sel;
    ctrl_val[cpu_instruction_clock_pkg::FAIL_BIT]    = st.fail_flag;
    ctrl_val[cpu_instruction_clock_pkg::RC_EN_BIT]   = st.rc_en;
    ctrl_val[cpu_instruction_clock_pkg::SRC_SEL_BIT] = st.src_sel;
    stat_val = '0;
    stat_val[cpu_instruction_clock_pkg::STAT_RC_SEL_BIT] = rc_selected;
    stat_val[cpu_instruction_clock_pkg::STAT_MON_BIT]    = st.monitor_active;
    stat_val[cpu_instruction_clock_pkg::STAT_WDT_BIT]    =
      st.source == cpu_instruction_clock_pkg::SRC_WDT;
    stat_val[cpu_instruction_clock_pkg::STAT_CFG_BIT]    = cfg_valid;
    stat_val[cpu_instruction_clock_pkg::STAT_RC_ON_BIT]  = st.rc_on_out;
    stat_val[cpu_instruction_clock_pkg::STAT_SPD_BIT]    = st.speedup_out;
    stat_val[cpu_instruction_clock_pkg::STAT_DIV_HI_BIT:cpu_instruction_clock_pkg::STAT_DIV_LO_BIT] =
      eff_div;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.sync_a = {oscillator_config_option,
                      oscillator_failed,
                      watchdog_rc_clock,
                      internal_rc_clock,
                      selected_oscillator_clock};
    next_st.sync_b   = st.sync_a;
    next_st.clk_prev = st.sync_b[cpu_instruction_clock_pkg::CLK_W-1:0];

    // software writes, stored whatever the option
    if (wr_ctrl)
    begin
      next_st.speedup = pwdata[cpu_instruction_clock_pkg::SPEEDUP_BIT];
      next_st.div_sel =
        pwdata[cpu_instruction_clock_pkg::DIV_HI_BIT:cpu_instruction_clock_pkg::DIV_LO_BIT];
      next_st.src_sel = pwdata[cpu_instruction_clock_pkg::SRC_SEL_BIT];
      next_st.rc_en   = pwdata[cpu_instruction_clock_pkg::RC_EN_BIT] ||
                        (st.rc_en && st.src_sel);
    end

    // failure flag, hardware only; a failure wins over recovery
    if (osc_failed && monitor_on)
      next_st.fail_flag = 1'b1;
    else if (!osc_failed)
      next_st.fail_flag = 1'b0;

    // source of the prescaler input
    if (rc_selected)
      next_st.source = cpu_instruction_clock_pkg::SRC_RC;
    else if (st.fail_flag && monitor_on)
      next_st.source = cpu_instruction_clock_pkg::SRC_WDT;
    else
      next_st.source = cpu_instruction_clock_pkg::SRC_LF;

    case (next_st.source)
      cpu_instruction_clock_pkg::SRC_RC:  next_st.tick = rising[cpu_instruction_clock_pkg::PIN_RC];
      cpu_instruction_clock_pkg::SRC_WDT: next_st.tick = rising[cpu_instruction_clock_pkg::PIN_WDT];
      default:             next_st.tick = rising[cpu_instruction_clock_pkg::PIN_LF];
    endcase

    next_st.rc_on_out      = cfg_valid && st.rc_en;
    next_st.speedup_out    = cfg_valid && st.speedup;
    next_st.monitor_active = monitor_on;

    // read data captured in the setup phase
    if (psel && !penable)
    begin
      if (hit_ctrl)
        next_st.rd_data = ctrl_val;
      else if (hit_stat)
        next_st.rd_data = stat_val;
      else
        next_st.rd_data = '0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= ST_RESET;
    else if (clk_en)
      st <= next_st;
  end

  // ==========================================================
  // prescaler
  cpu_clock_divider u_divider (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .in_tick     (st.tick),
    .divide_code (st.div_sel),
    .bypass      (bypass),
    .out_tick    (cpu_instruction_clock)
  );

  assign internal_rc_enable    = st.rc_on_out;
  assign low_freq_osc_speedup  = st.speedup_out;
  assign clock_failure_flag    = st.fail_flag;
  assign clock_monitor_active  = st.monitor_active;
  assign prescaler_input_clock = st.tick;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_reset_sets_speedup: assert property (
    @(posedge core_clk) disable iff (1'b0)
    sys_rst |=> (st.speedup && st.div_sel == cpu_instruction_clock_pkg::DIV_RST)
  ) else $error("speedup not set by reset");

  a_speedup_write: assert property (
    clk_en && wr_ctrl
    |=> st.speedup == $past(pwdata[cpu_instruction_clock_pkg::SPEEDUP_BIT])
  ) else $error("speedup write not stored");

  a_speedup_gated: assert property (
    clk_en && !cfg_valid |=> !low_freq_osc_speedup
  ) else $error("speedup active outside option");

  a_rc_enable_out: assert property (
    clk_en |=> internal_rc_enable == $past(cfg_valid && st.rc_en)
  ) else $error("rc enable output wrong");

  a_rc_clear_refused: assert property (
    clk_en && st.rc_en && st.src_sel |=> st.rc_en
  ) else $error("rc enable cleared while selected");

  a_monitor_blocked: assert property (
    clk_en && rc_selected
    |=> (st.source == cpu_instruction_clock_pkg::SRC_RC && !clock_monitor_active)
  ) else $error("monitor active with rc selected");

  a_flag_recovers: assert property (
    clk_en && !osc_failed |=> !clock_failure_flag
  ) else $error("failure flag not cleared");

  a_flag_sets: assert property (
    clk_en && osc_failed && monitor_on |=> clock_failure_flag
  ) else $error("failure flag not set");

  a_lf_undivided: assert property (
    clk_en && bypass && st.tick |=> cpu_instruction_clock
  ) else $error("low-frequency tick divided");

  a_cpu_from_input: assert property (
    cpu_instruction_clock |-> $past(st.tick)
  ) else $error("cpu tick without input tick");

  a_invalid_stored: assert property (
    clk_en && wr_ctrl && !cfg_valid
    |=> (st.src_sel == $past(pwdata[cpu_instruction_clock_pkg::SRC_SEL_BIT])
         && !internal_rc_enable)
  ) else $error("invalid write mishandled");

  a_flag_held_blocked: assert property (
    clk_en && osc_failed && !monitor_on |=> $stable(clock_failure_flag)
  ) else $error("failure flag moved with monitor off");

  a_wdt_on_failure: assert property (
    clk_en && st.fail_flag && !rc_selected
    |=> st.source == cpu_instruction_clock_pkg::SRC_WDT
  ) else $error("watchdog clock not used on failure");

  a_lf_default_source: assert property (
    clk_en && !rc_selected && !st.fail_flag
    |=> st.source == cpu_instruction_clock_pkg::SRC_LF
  ) else $error("oscillator not used as default source");

  a_rc_needs_option: assert property (
    clk_en && !cfg_valid
    |=> (st.source != cpu_instruction_clock_pkg::SRC_RC && !internal_rc_enable)
  ) else $error("rc used outside option");

  a_div_stored: assert property (
    clk_en && wr_ctrl
    |=> st.div_sel
        == $past(pwdata[cpu_instruction_clock_pkg::DIV_HI_BIT:cpu_instruction_clock_pkg::DIV_LO_BIT])
  ) else $error("divider write not stored");

  a_rc_en_set: assert property (
    clk_en && wr_ctrl && pwdata[cpu_instruction_clock_pkg::RC_EN_BIT] |=> st.rc_en
  ) else $error("rc enable write not stored");

  a_speedup_follows: assert property (
    clk_en && cfg_valid |=> low_freq_osc_speedup == $past(st.speedup)
  ) else $error("speedup output wrong under option");

  a_monitor_enabled: assert property (
    clk_en && !rc_selected |=> clock_monitor_active
  ) else $error("monitor off without rc selected");

  a_src_stored: assert property (
    clk_en && wr_ctrl
    |=> st.src_sel == $past(pwdata[cpu_instruction_clock_pkg::SRC_SEL_BIT])
  ) else $error("source write not stored");

  a_read_capture: assert property (
    clk_en && psel && !penable && hit_ctrl |=> st.rd_data == $past(ctrl_val)
  ) else $error("control read data not captured");

  a_rc_tick_source: assert property (
    clk_en && rc_selected
    |=> prescaler_input_clock == $past(rising[cpu_instruction_clock_pkg::PIN_RC])
  ) else $error("input tick not from rc");

  c_rc_switch: cover property (
    clk_en && st.rc_en && !st.src_sel && cfg_valid && wr_ctrl
    && pwdata[cpu_instruction_clock_pkg::SRC_SEL_BIT]
  );

  c_failover: cover property (
    $rose(clock_failure_flag) ##[1:20] !clock_failure_flag
  );

  c_refused_clear: cover property (
    wr_ctrl && st.rc_en && st.src_sel
    && !pwdata[cpu_instruction_clock_pkg::RC_EN_BIT]
  );

  c_watchdog_tick: cover property (
    st.source == cpu_instruction_clock_pkg::SRC_WDT && st.tick
  );

  c_divide_twelve: cover property (
    st.div_sel == cpu_instruction_clock_pkg::DIV_CODE_4 + 2'h1 && !bypass
    && cpu_instruction_clock
  );

endmodule
`default_nettype wire

//--- design/cpu_instruction_clock_pkg.sv
// constants and types shared by the system clock control block
`default_nettype none
package cpu_instruction_clock_pkg;

  // ==========================================================
  // bus
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // ==========================================================
  // register indices and byte addresses
  localparam logic [ADDR_W-1:0] CLK_CTRL_INDEX = 12'h0b2;
  localparam logic [ADDR_W-1:0] CLK_STAT_INDEX = 12'h0b3;
  localparam logic [ADDR_W-1:0] CLK_CTRL_ADDR  =
    {CLK_CTRL_INDEX[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] CLK_STAT_ADDR  =
    {CLK_STAT_INDEX[ADDR_W-3:0], 2'h0};

  // ==========================================================
  // control register fields
  localparam int SPEEDUP_BIT = 7;
  localparam int DIV_HI_BIT  = 6;
  localparam int DIV_LO_BIT  = 5;
  localparam int FAIL_BIT    = 4;
  localparam int RC_EN_BIT   = 3;
  localparam int SRC_SEL_BIT = 2;

  // control register reset values
  localparam logic       SPEEDUP_RST = 1'h1;
  localparam logic [1:0] DIV_RST     = 2'h3;
  localparam logic       FAIL_RST    = 1'h0;
  localparam logic       RC_EN_RST   = 1'h0;
  localparam logic       SRC_SEL_RST = 1'h0;

  // ==========================================================
  // status register fields
  localparam int STAT_RC_SEL_BIT = 0;
  localparam int STAT_MON_BIT    = 1;
  localparam int STAT_WDT_BIT    = 2;
  localparam int STAT_CFG_BIT    = 3;
  localparam int STAT_RC_ON_BIT  = 4;
  localparam int STAT_SPD_BIT    = 5;
  localparam int STAT_DIV_LO_BIT = 6;
  localparam int STAT_DIV_HI_BIT = 7;

  // ==========================================================
  // oscillator option and divider
  localparam logic [2:0] CFG_LF_XTAL = 3'h3;
  localparam logic [1:0] DIV_CODE_1  = 2'h0;
  localparam logic [1:0] DIV_CODE_2  = 2'h1;
  localparam logic [1:0] DIV_CODE_4  = 2'h2;
  localparam logic [3:0] DIV_TERM_1  = 4'h0;
  localparam logic [3:0] DIV_TERM_2  = 4'h1;
  localparam logic [3:0] DIV_TERM_4  = 4'h3;
  localparam logic [3:0] DIV_TERM_12 = 4'hb;

  // ==========================================================
  // pin synchroniser lanes
  localparam int PIN_LF   = 0;
  localparam int PIN_RC   = 1;
  localparam int PIN_WDT  = 2;
  localparam int PIN_FAIL = 3;
  localparam int PIN_CFG  = 4;
  localparam int SYNC_W   = 7;
  localparam int CLK_W    = 3;

  typedef enum logic [1:0] {SRC_LF, SRC_RC, SRC_WDT} source_t;

endpackage
`default_nettype wire

//--- design/cpu_clock_divider.sv
// prescaler dividing input ticks by 1, 2, 4 or 12
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_divider (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // prescaler input
  input  wire logic       in_tick,
  input  wire logic [1:0] divide_code,
  input  wire logic       bypass,
  // cpu clock tick
  output logic            out_tick
);

  typedef struct packed {
    logic [3:0] count;
    logic       out_tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic [3:0] term;

  // ==========================================================
  // divide ratio
  always_comb
  begin
    next_st = st;
    case (divide_code)
      cpu_instruction_clock_pkg::DIV_CODE_1: term = cpu_instruction_clock_pkg::DIV_TERM_1;
      cpu_instruction_clock_pkg::DIV_CODE_2: term = cpu_instruction_clock_pkg::DIV_TERM_2;
      cpu_instruction_clock_pkg::DIV_CODE_4: term = cpu_instruction_clock_pkg::DIV_TERM_4;
      default:                term = cpu_instruction_clock_pkg::DIV_TERM_12;
    endcase
    next_st.out_tick = 1'b0;
    if (in_tick)
    begin
      if (bypass || st.count >= term)
      begin
        next_st.out_tick = 1'b1;
        next_st.count    = 4'h0;
      end
      else
      begin
        next_st.count = 4'(st.count + 4'h1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign out_tick = st.out_tick;

endmodule
`default_nettype wire

//--- dv/osc_source_model.sv
// far-side model: low-frequency crystal, internal rc and watchdog rc
`timescale 1ns/100ps
`default_nettype none
module osc_source_model #(
  parameter int LF_HALF_NS  = 200,
  parameter int RC_HALF_NS  = 75,
  parameter int WDT_HALF_NS = 250
) (
  // controls from the block and the bench
  input  wire logic internal_rc_enable,
  input  wire logic fail_cmd,
  // oscillator pins
  output logic      selected_oscillator_clock,
  output logic      internal_rc_clock,
  output logic      watchdog_rc_clock,
  output logic      oscillator_failed
);
  // ==========================================
  // clock sources
  initial
  begin
    selected_oscillator_clock = 1'b0;
    forever
    begin
      #(LF_HALF_NS);
      if (!fail_cmd)
        selected_oscillator_clock = ~selected_oscillator_clock;
    end
  end
  initial
  begin
    internal_rc_clock = 1'b0;
    forever
    begin
      #(RC_HALF_NS);
      internal_rc_clock = internal_rc_enable & ~internal_rc_clock;
    end
  end
  initial
  begin
    watchdog_rc_clock = 1'b0;
    forever
    begin
      #(WDT_HALF_NS);
      watchdog_rc_clock = ~watchdog_rc_clock;
    end
  end
  assign oscillator_failed = fail_cmd;
endmodule
`default_nettype wire

//--- dv/test_system_clock_control.sv
// self-checking bench for the system clock control block
`timescale 1ns/100ps
`default_nettype none
module test_system_clock_control;
  localparam logic [11:0] CTRL = cpu_instruction_clock_pkg::CLK_CTRL_ADDR;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        clk_en   = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [3:0]  pstrb    = 4'hf;
  logic [2:0]  opt      = 3'h3;
  logic        fail_cmd = 1'b0;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, err, rc_en, spd, flag, mon, in_tk, cpu_tk;
  logic        lf_clk, rc_clk, wdt_clk, osc_fail;
  int          failures = 0;
  int          compares = 0;
  int          cycles   = 0;
  int          divs [4] = '{1, 2, 4, 12};

  always #12.5 core_clk = ~core_clk;

  system_clock_control i_system_clock_control (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .selected_oscillator_clock(lf_clk),
    .internal_rc_clock(rc_clk), .watchdog_rc_clock(wdt_clk),
    .oscillator_failed(osc_fail), .oscillator_config_option(opt),
    .internal_rc_enable(rc_en), .low_freq_osc_speedup(spd),
    .clock_failure_flag(flag), .clock_monitor_active(mon),
    .prescaler_input_clock(in_tk), .cpu_instruction_clock(cpu_tk));

  osc_source_model i_osc_source_model (
    .internal_rc_enable(rc_en), .fail_cmd(fail_cmd),
    .selected_oscillator_clock(lf_clk), .internal_rc_clock(rc_clk),
    .watchdog_rc_clock(wdt_clk), .oscillator_failed(osc_fail));

  // ==========================================
  // report and tasks
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic wait_cpu();
    do @(negedge core_clk); while (cpu_tk !== 1'b1);
  endtask

  // input ticks between two cpu ticks equal the divide ratio
  task automatic measure(input int expd);
    int n;
    n = 0;
    wait_cpu();
    wait_cpu();
    do
    begin
      @(negedge core_clk);
      if (in_tk === 1'b1)
        n++;
    end
    while (cpu_tk !== 1'b1);
    chk(n, expd);
  endtask

  task automatic reset_dut();
    sys_rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask

  // ==========================================
  // tests
  initial
  begin
    reset_dut();
    rd_chk(CTRL, 32'he0);
    // speedup output rises on the last edge of the read; sampled on the next falling edge
    @(negedge core_clk);
    chk(spd, 1'b1);
    apb(1'b1, CTRL, 32'h60);
    rd_chk(CTRL, 32'h60);
    chk(spd, 1'b0);
    apb(1'b1, CTRL, 32'hf0);
    rd_chk(CTRL, 32'he0);
    apb(1'b0, 12'h000, 32'h0);
    chk({rdv[7:0], 7'h0, err}, 16'h0001);
    measure(1);
    apb(1'b1, CTRL, 32'he8);
    repeat (4) @(posedge core_clk);
    chk(rc_en, 1'b1);
    // over two low-frequency periods of the model
    repeat (40) @(posedge core_clk);
    apb(1'b1, CTRL, 32'hec);
    repeat (4) @(posedge core_clk);
    chk(mon, 1'b0);
    apb(1'b0, cpu_instruction_clock_pkg::CLK_STAT_ADDR, 32'h0);
    chk(rdv[cpu_instruction_clock_pkg::STAT_RC_SEL_BIT], 1'b1);
    measure(12);
    apb(1'b1, CTRL, 32'he4);
    rd_chk(CTRL, 32'hec);
    chk(rc_en, 1'b1);
    apb(1'b1, CTRL, 32'he8);
    apb(1'b1, CTRL, 32'he0);
    repeat (4) @(posedge core_clk);
    chk({rc_en, mon}, 2'h1);
    fail_cmd <= 1'b1;
    repeat (30) @(posedge core_clk);
    rd_chk(CTRL, 32'hf0);
    chk(flag, 1'b1);
    fail_cmd <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd_chk(CTRL, 32'he0);
    opt <= 3'h0;
    reset_dut();
    rd_chk(CTRL, 32'he0);
    apb(1'b1, CTRL, 32'h8c);
    rd_chk(CTRL, 32'h8c);
    chk({rc_en, spd}, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, CTRL, {24'h0, 1'b1, 2'(i), 5'h0c});
      measure(divs[i]);
    end
    results();
  end
endmodule
`default_nettype wire
